// [rtl/irq_agg_cfg.svh]
`ifndef IRQ_AGG_CFG_SVH
`define IRQ_AGG_CFG_SVH

// Device register offsets on the link command port.
`define OFS_IRQ_ENABLE      8'h00
`define OFS_IRQ_FLAG        8'h01
`define OFS_ETH_STATUS      8'h02

// Source bit positions shared by the enable and flag registers; bit 7 is the enable-only global enable and the status summary.
`define BIT_RX_ERROR        0
`define BIT_TX_ERROR        1
`define BIT_TX_DONE         3
`define BIT_LINK_CHANGE     4
`define BIT_COPY_DONE       5
`define BIT_RX_PENDING      6
`define BIT_GLOBAL_EN       7
`define BIT_SUMMARY         7

// Implemented bits and reset values.
`define SRC_MASK            8'h7b
`define ENABLE_MASK         8'hfb
`define IRQ_ENABLE_RESET    8'h00
`define IRQ_FLAG_RESET      8'h00

// Host controller register offsets on the software port.
`define HOST_OFS_CMD        4'h0
`define HOST_OFS_DEV_ADDR   4'h1
`define HOST_OFS_DEV_WDATA  4'h2
`define HOST_OFS_DEV_RDATA  4'h3
`define HOST_OFS_STATUS     4'h4
`define HOST_OFS_MASK       4'h5

// Host status and mask bit positions.
`define HOST_BIT_EDGE       0
`define HOST_BIT_RDONE      1
`define HOST_STATUS_RESET   2'h0

`endif

// [rtl/irq_agg_pkg.sv]
package irq_agg_pkg;

    typedef enum logic [1:0]
    {
        OP_READ  = 2'h0,
        OP_WRITE = 2'h1,
        OP_SET   = 2'h2,
        OP_CLEAR = 2'h3
    } cmd_op_t;

    typedef logic [7:0] reg_byte_t;

endpackage : irq_agg_pkg

// [rtl/irq_link_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface irq_link_if;
    import irq_agg_pkg::*;

    logic      cmd_valid;
    cmd_op_t   cmd_op;
    reg_byte_t cmd_addr;
    reg_byte_t cmd_wdata;
    logic      rsp_valid;
    reg_byte_t rsp_data;
    logic      irq_out_n;

    modport device_end
    (
        input  cmd_valid,
        input  cmd_op,
        input  cmd_addr,
        input  cmd_wdata,
        output rsp_valid,
        output rsp_data,
        output irq_out_n
    );

    modport host_end
    (
        output cmd_valid,
        output cmd_op,
        output cmd_addr,
        output cmd_wdata,
        input  rsp_valid,
        input  rsp_data,
        input  irq_out_n
    );

endinterface : irq_link_if

`default_nettype wire

// [rtl/irq_aggregator_device.sv]
// How it works
// - One interrupt pin; host senses falling edges.
// - Enable bit and flag bit per source.
// - Event sets flag; enabled flag drives pin low.
// - Flags set regardless of enables, except link.
// - Pin stays low until flags cleared or masked.
// - Host clears flags before enabling a source.
// - Host reads flags to find the cause.
// - Host clears flags with bit clear command.
// - Clearing global enable releases pin high two clocks after the command.
// - Re-enabling global with pending event drives low again.
// - Global enable gates exactly the six sources.
// - Summary bit shows enabled pending source, ungated.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

`include "irq_agg_cfg.svh"

module irq_aggregator_device
    import irq_agg_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Link toward the host
    irq_link_if.device_end   link,
    // Event pulses from the controller datapath
    input  wire logic        rx_error_evt,
    input  wire logic        tx_error_evt,
    input  wire logic        tx_done_evt,
    input  wire logic        link_change_evt,
    input  wire logic        copy_done_evt,
    input  wire logic        rx_pending_evt,
    // Status views
    output logic             irq_summary,
    output logic [7:0]       flag_view,
    output logic [7:0]       enable_view
);

    // Applies one register command to an old register value.
    function automatic reg_byte_t apply_cmd
    (
        input reg_byte_t old_val,
        input cmd_op_t   op,
        input reg_byte_t data
    );
        reg_byte_t res;
        res = old_val;
        case (op)
            OP_WRITE:
            begin
                res = data;
            end
            OP_SET:
            begin
                res = old_val | data;
            end
            OP_CLEAR:
            begin
                res = old_val & ~data;
            end
            default:
            begin
                res = old_val;
            end
        endcase
        return res;
    endfunction : apply_cmd

    // Tells whether a command of the given kind addresses a register.
    function automatic logic cmd_hits
    (
        input logic      valid,
        input reg_byte_t addr,
        input reg_byte_t ofs
    );
        return valid && (addr == ofs);
    endfunction : cmd_hits

    reg_byte_t irq_enable_reg;
    reg_byte_t irq_enable_next;
    reg_byte_t irq_flag_reg;
    reg_byte_t irq_flag_next;
    logic      summary_reg;
    logic      summary_next;
    logic      irq_out_n_reg;
    logic      irq_out_n_next;
    logic      rsp_valid_reg;
    logic      rsp_valid_next;
    reg_byte_t rsp_data_reg;
    reg_byte_t rsp_data_next;

    wire logic      is_read;
    wire logic      is_modify;
    wire logic      hit_enable;
    wire logic      hit_flag;
    wire logic      hit_status;
    wire logic      rd_enable;
    wire logic      rd_flag;
    wire reg_byte_t evt_vec;
    wire reg_byte_t evt_set;
    wire reg_byte_t flag_after_cmd;
    wire reg_byte_t enable_after_cmd;
    wire logic      link_allowed;
    wire logic      pending;
    wire reg_byte_t status_view;

    assign is_read    = link.cmd_valid && (link.cmd_op == OP_READ);
    assign is_modify  = link.cmd_valid && (link.cmd_op != OP_READ);
    assign hit_enable = cmd_hits(is_modify, link.cmd_addr, `OFS_IRQ_ENABLE);
    assign hit_flag   = cmd_hits(is_modify, link.cmd_addr, `OFS_IRQ_FLAG);
    assign hit_status = cmd_hits(is_read, link.cmd_addr, `OFS_ETH_STATUS);
    assign rd_enable  = cmd_hits(is_read, link.cmd_addr, `OFS_IRQ_ENABLE);
    assign rd_flag    = cmd_hits(is_read, link.cmd_addr, `OFS_IRQ_FLAG);

    // Event pulses gathered into the flag layout.
    assign evt_vec =
    {
        1'b0,
        rx_pending_evt,
        copy_done_evt,
        link_change_evt,
        tx_done_evt,
        1'b0,
        tx_error_evt,
        rx_error_evt
    };

    // The link flag only records while its own source is enabled.
    assign link_allowed = irq_enable_reg[`BIT_LINK_CHANGE];
    assign evt_set = evt_vec & `SRC_MASK & ~({7'h00, ~link_allowed} << `BIT_LINK_CHANGE);

    assign enable_after_cmd = hit_enable ? apply_cmd(irq_enable_reg, link.cmd_op, link.cmd_wdata)
                                         : irq_enable_reg;
    assign flag_after_cmd   = hit_flag ? apply_cmd(irq_flag_reg, link.cmd_op, link.cmd_wdata)
                                       : irq_flag_reg;

    // Only the six sources take part in the pending term.
    assign pending = |(irq_flag_reg & irq_enable_reg & `SRC_MASK);

    assign status_view = {summary_reg, 7'h00};

    always_comb
    begin
        irq_enable_next = enable_after_cmd & `ENABLE_MASK;
        // An event wins over a clear that lands in the same cycle.
        irq_flag_next   = (flag_after_cmd & `SRC_MASK) | evt_set;
        // The summary ignores the global enable.
        summary_next    = pending;
        // The pin follows the enabled pending term, released one clock after global drops.
        irq_out_n_next  = ~(irq_enable_reg[`BIT_GLOBAL_EN] & pending);
        rsp_valid_next  = is_read;
        rsp_data_next   = 8'h00;
        if (rd_enable)
        begin
            rsp_data_next = irq_enable_reg;
        end
        else if (rd_flag)
        begin
            rsp_data_next = irq_flag_reg;
        end
        else if (hit_status)
        begin
            rsp_data_next = status_view;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_enable_reg <= `IRQ_ENABLE_RESET;
            irq_flag_reg   <= `IRQ_FLAG_RESET;
            summary_reg    <= 1'b0;
            irq_out_n_reg  <= 1'b1;
        end
        else
        begin
            irq_enable_reg <= irq_enable_next;
            irq_flag_reg   <= irq_flag_next;
            summary_reg    <= summary_next;
            irq_out_n_reg  <= irq_out_n_next;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg  <= 8'h00;
        end
        else
        begin
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg  <= rsp_data_next;
        end
    end

    assign link.irq_out_n = irq_out_n_reg;
    assign link.rsp_valid = rsp_valid_reg;
    assign link.rsp_data  = rsp_data_reg;
    assign irq_summary    = summary_reg;
    assign flag_view      = irq_flag_reg;
    assign enable_view    = irq_enable_reg;

endmodule : irq_aggregator_device

`default_nettype wire

// [rtl/irq_aggregator_host.sv]
`timescale 1ns/1ps
`default_nettype none

`include "irq_agg_cfg.svh"

module irq_aggregator_host
    import irq_agg_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Link toward the device
    irq_link_if.host_end     link,
    // Software port
    input  wire logic [3:0]  cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    output logic [7:0]       cpu_rdata,
    // Interrupt toward software
    output logic             irq
);

    logic      cmd_valid_reg;
    cmd_op_t   cmd_op_reg;
    reg_byte_t dev_addr_reg;
    reg_byte_t dev_wdata_reg;
    reg_byte_t dev_rdata_reg;
    logic [1:0] status_reg;
    logic [1:0] status_next;
    logic [1:0] mask_reg;
    logic      pin_prev_reg;
    reg_byte_t cpu_rdata_reg;
    reg_byte_t cpu_rdata_next;
    logic      irq_reg;

    wire logic       wr_cmd;
    wire logic       falling;
    wire logic [1:0] status_set;
    wire logic [1:0] status_clr;

    function automatic logic wr_hit
    (
        input logic       wr,
        input logic [3:0] addr,
        input logic [3:0] ofs
    );
        return wr && (addr == ofs);
    endfunction : wr_hit

    assign wr_cmd     = wr_hit(cpu_wr, cpu_addr, `HOST_OFS_CMD);
    // The pin is sensed by its falling edge only.
    assign falling    = pin_prev_reg & ~link.irq_out_n;
    assign status_set = {link.rsp_valid, falling};
    assign status_clr = wr_hit(cpu_wr, cpu_addr, `HOST_OFS_STATUS) ? cpu_wdata[1:0] : 2'h0;

    always_comb
    begin
        status_next    = (status_reg & ~status_clr) | status_set;
        cpu_rdata_next = 8'h00;
        case (cpu_addr)
            `HOST_OFS_DEV_ADDR:  cpu_rdata_next = dev_addr_reg;
            `HOST_OFS_DEV_WDATA: cpu_rdata_next = dev_wdata_reg;
            `HOST_OFS_DEV_RDATA: cpu_rdata_next = dev_rdata_reg;
            `HOST_OFS_STATUS:    cpu_rdata_next = {6'h00, status_reg};
            `HOST_OFS_MASK:      cpu_rdata_next = {6'h00, mask_reg};
            default:             cpu_rdata_next = 8'h00;
        endcase
        if (!cpu_rd)
        begin
            cpu_rdata_next = 8'h00;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd_valid_reg <= 1'b0;
            cmd_op_reg    <= OP_READ;
            dev_addr_reg  <= 8'h00;
            dev_wdata_reg <= 8'h00;
        end
        else
        begin
            cmd_valid_reg <= wr_cmd;
            cmd_op_reg    <= wr_cmd ? cmd_op_t'(cpu_wdata[1:0]) : cmd_op_reg;
            dev_addr_reg  <= wr_hit(cpu_wr, cpu_addr, `HOST_OFS_DEV_ADDR) ? cpu_wdata : dev_addr_reg;
            dev_wdata_reg <= wr_hit(cpu_wr, cpu_addr, `HOST_OFS_DEV_WDATA) ? cpu_wdata : dev_wdata_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dev_rdata_reg <= 8'h00;
            status_reg    <= `HOST_STATUS_RESET;
            mask_reg      <= 2'h0;
            pin_prev_reg  <= 1'b1;
            cpu_rdata_reg <= 8'h00;
            irq_reg       <= 1'b0;
        end
        else
        begin
            dev_rdata_reg <= link.rsp_valid ? link.rsp_data : dev_rdata_reg;
            status_reg    <= status_next;
            mask_reg      <= wr_hit(cpu_wr, cpu_addr, `HOST_OFS_MASK) ? cpu_wdata[1:0] : mask_reg;
            pin_prev_reg  <= link.irq_out_n;
            cpu_rdata_reg <= cpu_rdata_next;
            irq_reg       <= |(status_reg & mask_reg);
        end
    end

    assign link.cmd_valid = cmd_valid_reg;
    assign link.cmd_op    = cmd_op_reg;
    assign link.cmd_addr  = dev_addr_reg;
    assign link.cmd_wdata = dev_wdata_reg;
    assign cpu_rdata      = cpu_rdata_reg;
    assign irq            = irq_reg;

endmodule : irq_aggregator_host

`default_nettype wire

// [testbench/irq_link_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "irq_agg_cfg.svh"
module irq_link_assertions
    import irq_agg_pkg::*;
(
    // Clock and reset
    input wire logic      mclk,
    input wire logic      rst_b,
    // Link signals
    input wire logic      cmd_valid,
    input wire cmd_op_t   cmd_op,
    input wire reg_byte_t cmd_addr,
    input wire reg_byte_t cmd_wdata,
    input wire logic      rsp_valid,
    input wire reg_byte_t rsp_data,
    input wire logic      irq_out_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire rd_cmd = cmd_valid && cmd_op == OP_READ;
    wire en_cmd = cmd_valid && cmd_addr == `OFS_IRQ_ENABLE;
    wire gl_off = en_cmd && ((cmd_op == OP_WRITE && !cmd_wdata[7]) || (cmd_op == OP_CLEAR && cmd_wdata[7]));
    rsp_after_read_a: assert property (rd_cmd |=> rsp_valid)
        else $error("read answer missing");
    rsp_only_read_a: assert property (rsp_valid |-> $past(rd_cmd))
        else $error("answer without read");
    rsp_idle_zero_a: assert property (!rsp_valid |-> rsp_data == 8'h00)
        else $error("idle answer data not zero");
    global_release_a: assert property (gl_off |-> ##2 irq_out_n)
        else $error("pin not released");
    enable_layout_a: assert property (rsp_valid && $past(cmd_addr) == 8'h00 |-> !rsp_data[2])
        else $error("enable spare bit set");
    flag_layout_a: assert property (rsp_valid && $past(cmd_addr) == 8'h01 |-> (rsp_data & 8'h84) == 8'h00)
        else $error("flag spare bits set");
    status_layout_a: assert property (rsp_valid && $past(cmd_addr) == 8'h02 |-> rsp_data[6:0] == 7'h00)
        else $error("status spare bits set");
    unmapped_zero_a: assert property (rsp_valid && $past(cmd_addr) > 8'h02 |-> rsp_data == 8'h00)
        else $error("unmapped read not zero");
endmodule : irq_link_assertions
`default_nettype wire

// [testbench/host_interrupt_aggregator_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module host_interrupt_aggregator_tb
    import irq_agg_pkg::*;
;
    logic       mclk = 1'b0;
    logic       rst_b = 1'b0;
    logic [3:0] cpu_addr = 4'h0;
    logic [7:0] cpu_wdata = 8'h00;
    logic       cpu_wr = 1'b0;
    logic       cpu_rd = 1'b0;
    logic [5:0] evt = 6'h00;
    logic [7:0] cpu_rdata, flag_view, enable_view, m;
    logic       irq, irq_summary, rd_seen = 1'b0;
    logic [15:0] seed = 16'h9099;
    int         error_cnt = 0, tests_run = 0, i;
    reg_byte_t  q[$];
    int         bpos[6] = '{0, 1, 3, 4, 5, 6};
    irq_link_if irq_link_if_i();
    irq_aggregator_device irq_aggregator_device_i (.mclk(mclk), .rst_b(rst_b), .link(irq_link_if_i.device_end),
        .rx_error_evt(evt[0]), .tx_error_evt(evt[1]), .tx_done_evt(evt[2]), .link_change_evt(evt[3]),
        .copy_done_evt(evt[4]), .rx_pending_evt(evt[5]), .irq_summary(irq_summary), .flag_view(flag_view),
        .enable_view(enable_view));
    irq_aggregator_host irq_aggregator_host_i (.mclk(mclk), .rst_b(rst_b), .link(irq_link_if_i.host_end),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
        .irq(irq));
    irq_link_assertions irq_link_assertions_i (.mclk(mclk), .rst_b(rst_b), .cmd_valid(irq_link_if_i.cmd_valid),
        .cmd_op(irq_link_if_i.cmd_op), .cmd_addr(irq_link_if_i.cmd_addr), .cmd_wdata(irq_link_if_i.cmd_wdata),
        .rsp_valid(irq_link_if_i.rsp_valid), .rsp_data(irq_link_if_i.rsp_data),
        .irq_out_n(irq_link_if_i.irq_out_n));
    always #5 mclk = ~mclk;
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic results();
        if (error_cnt == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    task automatic check(input reg_byte_t seen, input reg_byte_t exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input reg_byte_t d);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge mclk);
        cpu_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input reg_byte_t e);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        q.push_back(e);
        @(posedge mclk);
        cpu_rd <= 1'b0;
    endtask : rd
    task automatic dop(input cmd_op_t op, input reg_byte_t a, input reg_byte_t d);
        wr(4'h1, a);
        wr(4'h2, d);
        wr(4'h0, {6'h00, op});
        tick(3);
    endtask : dop
    task automatic drd(input reg_byte_t a, input reg_byte_t e);
        wr(4'h1, a);
        wr(4'h0, 8'h00);
        tick(3);
        rd(4'h3, e);
    endtask : drd
    task automatic pulse(input int k);
        @(posedge mclk);
        evt[k] <= 1'b1;
        @(posedge mclk);
        evt <= 6'h00;
    endtask : pulse
    always @(posedge mclk) rd_seen <= cpu_rd;
    always @(negedge mclk) if (rd_seen) check(cpu_rdata, q.pop_front(), "cpu_rdata");
    initial
    begin
        #50000;
        error_cnt++;
        results();
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        tick(1);
        check(irq_link_if_i.irq_out_n, 8'h01, "pin");
        wr(4'h5, 8'h01);
        repeat (3)
        begin
            seed = lfsr_next(seed);
            dop(OP_WRITE, 8'h00, seed[7:0]);
            drd(8'h00, seed[7:0] & 8'hfb);
            check(enable_view, seed[7:0] & 8'hfb, "enable_view");
        end
        dop(OP_WRITE, 8'h00, 8'h00);
        for (i = 0; i < 6; i++) pulse(i);
        tick(2);
        check(flag_view, 8'h6b, "flag_view");
        check(irq_link_if_i.irq_out_n, 8'h01, "pin");
        drd(8'h01, 8'h6b);
        dop(OP_CLEAR, 8'h01, 8'hff);
        check(flag_view, 8'h00, "flag_view");
        for (i = 0; i < 6; i++)
        begin
            m = 8'h01 << bpos[i];
            dop(OP_WRITE, 8'h00, 8'h80 | m);
            pulse(i);
            tick(3);
            check(irq_link_if_i.irq_out_n, 8'h00, "pin");
            check(irq_summary, 8'h01, "irq_summary");
            drd(8'h02, 8'h80);
            check(irq, 8'h01, "irq");
            dop(OP_CLEAR, 8'h01, m);
            check(irq_link_if_i.irq_out_n, 8'h01, "pin");
            wr(4'h4, 8'h03);
        end
        dop(OP_WRITE, 8'h00, 8'h88);
        pulse(2);
        tick(3);
        check(irq_link_if_i.irq_out_n, 8'h00, "pin");
        dop(OP_CLEAR, 8'h00, 8'h80);
        check(irq_link_if_i.irq_out_n, 8'h01, "pin");
        wr(4'h4, 8'h03);
        drd(8'h02, 8'h80);
        dop(OP_SET, 8'h00, 8'h80);
        tick(3);
        check(irq_link_if_i.irq_out_n, 8'h00, "pin");
        check(irq, 8'h01, "irq");
        dop(OP_CLEAR, 8'h00, 8'h08);
        check(irq_link_if_i.irq_out_n, 8'h01, "pin");
        dop(OP_CLEAR, 8'h01, 8'hff);
        seed = lfsr_next(seed);
        i = seed % 5;
        if (i >= 3)
            i++;
        wr(4'h1, 8'h01);
        wr(4'h2, 8'hff);
        fork
            wr(4'h0, {6'h00, OP_CLEAR});
            begin
                @(posedge mclk);
                pulse(i);
            end
        join
        tick(2);
        check(flag_view, 8'h01 << bpos[i], "flag_view");
        dop(OP_SET, 8'h01, 8'h84);
        drd(8'h01, 8'h01 << bpos[i]);
        dop(OP_WRITE, 8'h02, 8'hff);
        drd(8'h02, 8'h00);
        drd(8'h09, 8'h00);
        rd(4'hf, 8'h00);
        tick(2);
        results();
    end
endmodule : host_interrupt_aggregator_tb
`default_nettype wire
